// ==== core/bpfl_defines.vh ====
// constants for the backup power flag logic: offsets, fields, reset values
`ifndef BPFL_DEFINES_VH
`define BPFL_DEFINES_VH

// ==========================================================
// register offsets (8-bit address)
`define BPFL_ADDR_CTRL2     8'h01
`define BPFL_ADDR_CTRL3     8'h02
`define BPFL_ADDR_OSC       8'h03

// ==========================================================
// control 3 fields
`define BPFL_PM_HI          7
`define BPFL_PM_LO          5
`define BPFL_BSF_BIT        3
`define BPFL_BLF_BIT        2
`define BPFL_SWITCHOVER_INT_ENABLE_BIT       1
`define BPFL_BATTERY_LOW_INT_ENABLE_BIT       0
`define BPFL_PM_RESET       3'h7

// control 2 field: clock output enable (shares the interrupt pin)
`define BPFL_CLKOE_BIT      0
// oscillator register field
`define BPFL_OS_BIT         7

// ==========================================================
// power mode codes
`define BPFL_PM_STD_LOW     3'h0
`define BPFL_PM_DIR_LOW     3'h1
`define BPFL_PM_OFF_LOW0    3'h2
`define BPFL_PM_OFF_LOW1    3'h3
`define BPFL_PM_STD         3'h4
`define BPFL_PM_DIR         3'h5
`define BPFL_PM_BAD         3'h6
`define BPFL_PM_OFF         3'h7

`endif

// ==== core/bpfl_flag.v ====
// one sticky status flag: hardware set wins over a host clear
`timescale 1ns/10ps
`include "bpfl_defines.vh"

module bpfl_flag #(
    parameter RESET_VAL = 1'b0
) (
    input  wire i_clk_sys,
    input  wire i_rst,
    input  wire i_set,
    input  wire i_clr,
    input  wire i_force_zero,
    output reg  o_flag
);

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_flag <= RESET_VAL;
        end else if (i_force_zero) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end

endmodule // bpfl_flag

// ==== core/bpfl_top.v ====
// power management control and status logic of the real-time clock
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "bpfl_defines.vh"

module bpfl_top #(
    parameter AW = 8
) (
    input  wire          i_clk_sys,
    input  wire          i_rst,
    // register port
    input  wire [AW-1:0] i_addr,
    input  wire [7:0]    i_wdata,
    input  wire          i_wr,
    input  wire          i_rd,
    output reg  [7:0]    o_rdata,
    output wire          o_if_oe,
    // comparator, backup presence, oscillator and clock output inputs
    input  wire          i_main_lt_backup,
    input  wire          i_main_lt_switch_threshold,
    input  wire          i_backup_lt_battery_low_threshold,
    input  wire          i_backup_present,
    input  wire          i_osc_stable,
    input  wire          i_clkout_int_n,
    // supply and interrupt
    output wire          o_on_battery,
    output wire          o_standby,
    output wire          o_int_n_o,
    output wire          o_int_n_oe
);

    // ==========================================================
    // control state
    reg  [2:0] power_mode_select;
    reg        switchover_int_enable;
    reg        battery_low_int_enable;
    reg        clkout_enable;
    reg        on_battery;
    reg        standby;
    wire       switchover_flag;
    wire       battery_low_flag;
    wire       oscillator_stop_flag;

    // ==========================================================
    // mode decode
    reg sw_enable;
    reg sw_direct;
    reg low_enable;

    always @* begin
        case (power_mode_select)
            `BPFL_PM_STD_LOW: begin
                sw_enable  = 1'b1;
                sw_direct  = 1'b0;
                low_enable = 1'b1;
            end
            `BPFL_PM_DIR_LOW: begin
                sw_enable  = 1'b1;
                sw_direct  = 1'b1;
                low_enable = 1'b1;
            end
            `BPFL_PM_OFF_LOW0, `BPFL_PM_OFF_LOW1: begin
                sw_enable  = 1'b0;
                sw_direct  = 1'b0;
                low_enable = 1'b1;
            end
            `BPFL_PM_STD: begin
                sw_enable  = 1'b1;
                sw_direct  = 1'b0;
                low_enable = 1'b0;
            end
            `BPFL_PM_DIR: begin
                sw_enable  = 1'b1;
                sw_direct  = 1'b1;
                low_enable = 1'b0;
            end
            default: begin
                // 110 is forbidden; treated like 111 so nothing misbehaves
                sw_enable  = 1'b0;
                sw_direct  = 1'b0;
                low_enable = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // power failure decision from comparator levels
    reg fail_cond;
    reg power_fail;
    reg main_ok;

    always @* begin
        main_ok = ~i_main_lt_backup;
        if (sw_direct) begin
            fail_cond = i_main_lt_backup;
        end else begin
            fail_cond = i_main_lt_backup & i_main_lt_switch_threshold;
        end
        power_fail = sw_enable & fail_cond;
    end

    // ==========================================================
    // supply state: reset is power-on, so we start undecided
    localparam [1:0] ST_START   = 2'b00;
    localparam [1:0] ST_STANDBY = 2'b01;
    localparam [1:0] ST_MAIN    = 2'b10;
    localparam [1:0] ST_BATTERY = 2'b11;

    reg  [1:0] supply_state;
    reg  [1:0] next_supply_state;
    wire       enter_batt = power_fail & (supply_state == ST_MAIN);

    always @* begin
        next_supply_state = supply_state;
        case (supply_state)
            ST_START: begin
                // first power from the battery alone parks in standby
                if (main_ok) begin
                    next_supply_state = ST_MAIN;
                end else if (i_backup_present) begin
                    next_supply_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                // nothing is drawn from the battery until main returns
                if (main_ok) begin
                    next_supply_state = ST_MAIN;
                end
            end
            ST_MAIN: begin
                if (~main_ok & ~sw_enable & i_backup_present) begin
                    next_supply_state = ST_STANDBY;
                end else if (power_fail) begin
                    next_supply_state = ST_BATTERY;
                end
            end
            ST_BATTERY: begin
                // back on main once the failure condition lifts
                if (~power_fail) begin
                    next_supply_state = ST_MAIN;
                end
            end
            default: begin
                next_supply_state = ST_START;
            end
        endcase
    end

    // the two status outputs are registered copies of the next state
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            supply_state <= ST_START;
            on_battery   <= 1'b0;
            standby      <= 1'b0;
        end else begin
            supply_state <= next_supply_state;
            on_battery   <= (next_supply_state == ST_BATTERY);
            standby      <= (next_supply_state == ST_STANDBY);
        end
    end

    // ==========================================================
    // host access is gated while on the backup supply
    wire host_live = ~on_battery & ~standby;
    wire wr_ok     = i_wr & host_live;
    wire rd_ok     = i_rd & host_live;
    wire wr_ctrl2  = wr_ok & (i_addr == `BPFL_ADDR_CTRL2);
    wire wr_ctrl3  = wr_ok & (i_addr == `BPFL_ADDR_CTRL3);
    wire wr_osc    = wr_ok & (i_addr == `BPFL_ADDR_OSC);

    // ==========================================================
    // flag strobes: a zero written to the switchover (with main good) or oscillator stop flag bit clears it
    wire sw_flag_clr  = wr_ctrl3 & main_ok & ~i_wdata[`BPFL_BSF_BIT];
    wire osc_flag_clr = wr_osc & ~i_wdata[`BPFL_OS_BIT];
    wire low_flag_set = low_enable & i_backup_lt_battery_low_threshold;
    wire low_flag_clr = ~i_backup_lt_battery_low_threshold;

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            power_mode_select      <= `BPFL_PM_RESET;
            switchover_int_enable  <= 1'b0;
            battery_low_int_enable <= 1'b0;
            clkout_enable          <= 1'b0;
        end else begin
            if (wr_ctrl3) begin
                power_mode_select      <= i_wdata[`BPFL_PM_HI:`BPFL_PM_LO];
                switchover_int_enable  <= i_wdata[`BPFL_SWITCHOVER_INT_ENABLE_BIT];
                battery_low_int_enable <= i_wdata[`BPFL_BATTERY_LOW_INT_ENABLE_BIT];
            end
            if (wr_ctrl2) begin
                clkout_enable <= i_wdata[`BPFL_CLKOE_BIT];
            end
        end
    end

    // ==========================================================
    // flags
    bpfl_flag #(.RESET_VAL(1'b0)) u_switchover (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_rst),
        .i_set        (enter_batt),
        .i_clr        (sw_flag_clr),
        .i_force_zero (~sw_enable),
        .o_flag       (switchover_flag)
    );

    // the low flag follows the detector but only sets while low detection is enabled: no host clear path at all
    bpfl_flag #(.RESET_VAL(1'b0)) u_battery_low (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_rst),
        .i_set        (low_flag_set),
        .i_clr        (low_flag_clr),
        .i_force_zero (1'b0),
        .o_flag       (battery_low_flag)
    );

    bpfl_flag #(.RESET_VAL(1'b1)) u_osc_stop (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_rst),
        .i_set        (~i_osc_stable),
        .i_clr        (osc_flag_clr),
        .i_force_zero (1'b0),
        .o_flag       (oscillator_stop_flag)
    );

    // ==========================================================
    // read port, data one cycle after the strobe
    reg [7:0] read_word;

    always @* begin
        case (i_addr)
            `BPFL_ADDR_CTRL2: begin
                read_word = {7'h00, clkout_enable};
            end
            `BPFL_ADDR_CTRL3: begin
                read_word = {power_mode_select, 1'b0, switchover_flag,
                             battery_low_flag, switchover_int_enable,
                             battery_low_int_enable};
            end
            `BPFL_ADDR_OSC: begin
                read_word = {oscillator_stop_flag, 7'h00};
            end
            default: begin
                read_word = 8'h00;
            end
        endcase
    end

    // the bus idles at zero so a stale value is never mistaken for data
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (rd_ok) begin
            o_rdata <= read_word;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // interrupt pin: open drain, low while a level source is active
    reg int_active;
    reg any_src;

    always @* begin
        int_active = 1'b0;
        if (switchover_int_enable & switchover_flag) begin
            int_active = 1'b1;
        end
        if (battery_low_int_enable & battery_low_flag) begin
            int_active = 1'b1;
        end
        // clock output shares the pin and pulls it while its level is low
        if (clkout_enable & ~i_clkout_int_n) begin
            int_active = 1'b1;
        end
        any_src = switchover_int_enable | battery_low_int_enable | clkout_enable;
    end

    assign o_int_n_o    = 1'b0;
    assign o_int_n_oe   = any_src & int_active;
    assign o_if_oe      = host_live;
    assign o_on_battery = on_battery;
    assign o_standby    = standby;

endmodule // bpfl_top

// ==== tb/bpfl_monitor.sv ====
// assertion checker for the backup power flag logic
`timescale 1ns/10ps
module bpfl_monitor #(
    parameter AW = 8
) (
    input wire logic          i_clk_sys, i_rst, i_wr, i_rd,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0]    i_wdata, o_rdata,
    input wire logic          i_main_lt_backup, i_main_lt_switch_threshold, i_osc_stable,
    input wire logic          o_if_oe, o_on_battery, o_standby, o_int_n_o, o_int_n_oe
);
    // ==========================================================
    // mirror of the mode field: only accepted writes count
    logic [2:0] mode;
    logic       acc, rd2, dis, dir, stdm, hold;
    assign acc  = !o_on_battery && !o_standby;
    assign rd2  = i_rd && acc && i_addr == 8'h02;
    assign dis  = mode[1];
    assign dir  = !mode[1] && mode[0];
    assign stdm = !mode[1] && !mode[0];
    assign hold = stdm && i_main_lt_backup && !i_main_lt_switch_threshold;
    always @(posedge i_clk_sys) begin
        if (i_rst) mode <= 3'h7;
        else if (i_wr && acc && i_addr == 8'h02) mode <= i_wdata[7:5];
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // assertions
    a_if_released: assert property (!acc |-> !o_if_oe)
        else $error("host interface driven while on battery or standby");
    a_pin_low: assert property (o_int_n_o == 1'b0)
        else $error("interrupt pin driven high");
    a_mode_read: assert property (rd2 && mode != 3'h6 |=> o_rdata[7:5] == $past(mode))
        else $error("mode field read back wrong");
    a_off_zero: assert property (rd2 && dis |=> !o_rdata[3])
        else $error("switchover flag set while switchover disabled");
    a_off_no_batt: assert property (dis |-> !o_on_battery)
        else $error("on battery while switchover disabled");
    a_direct_fail: assert property (dir && i_main_lt_backup && !o_standby |-> ##[1:2] o_on_battery)
        else $error("direct mode did not switch to battery");
    a_std_hold: assert property ((hold && !o_on_battery) ##1 hold [*3] |-> !o_on_battery)
        else $error("standard mode switched above the switch threshold");
    a_osc_sticky: assert property (i_rd && acc && i_addr == 8'h03 && $past(!i_osc_stable) |=> o_rdata[7])
        else $error("oscillator stop flag clear while stopped");
    a_int_follow: assert property ($past(rd2) && (o_rdata[3] && o_rdata[1] || o_rdata[2] && o_rdata[0]) |-> $past(o_int_n_oe))
        else $error("interrupt not asserted for an enabled flag");
    c_batt: cover property ($rose(o_on_battery));
    c_stby: cover property ($rose(o_standby));
    c_int: cover property ($rose(o_int_n_oe));
endmodule // bpfl_monitor

bind bpfl_top bpfl_monitor #(.AW(AW)) i_bpfl_monitor (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_main_lt_backup(i_main_lt_backup),
    .i_main_lt_switch_threshold(i_main_lt_switch_threshold), .i_osc_stable(i_osc_stable),
    .o_if_oe(o_if_oe), .o_on_battery(o_on_battery), .o_standby(o_standby),
    .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe));

// ==== tb/bpfl_host.sv ====
// host model driving the register port of the power logic
`timescale 1ns/10ps
module bpfl_host (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr  = 8'h00,
    output logic      [7:0] o_wdata = 8'h00,
    output logic            o_wr    = 1'b0,
    output logic            o_rd    = 1'b0
);
    // ==========================================================
    // one-cycle strobes; idle lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        o_addr  <= a;
        o_wdata <= v;
        // a mode 110 write is dropped rather than sent
        o_wr    <= (a != 8'h02) || (v[7:5] != 3'h6);
        @(posedge i_clk_sys);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk_sys);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
endmodule // bpfl_host

// ==== tb/tb_bpfl_top.sv ====
// testbench for the backup power flag logic
`timescale 1ns/10ps
module tb_bpfl_top;
    logic       i_clk_sys = 1'b0, i_rst = 1'b1;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic       i_wr, i_rd, o_if_oe, o_on_battery, o_standby, o_int_n_o, o_int_n_oe;
    logic       lt_b = 1'b0, lt_sw = 1'b0, low = 1'b0, osc = 1'b0, ck_n = 1'b1;
    int         n_fail = 0, n_tests = 0, k;
    logic [2:0] codes [7] = '{3'h4, 3'h5, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
    always #4 i_clk_sys = ~i_clk_sys;
    bpfl_top i_bpfl_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_if_oe(o_if_oe),
        .i_main_lt_backup(lt_b), .i_main_lt_switch_threshold(lt_sw),
        .i_backup_lt_battery_low_threshold(low), .i_backup_present(1'b1),
        .i_osc_stable(osc), .i_clkout_int_n(ck_n), .o_on_battery(o_on_battery),
        .o_standby(o_standby), .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe));
    bpfl_host i_bpfl_host (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
    // ==========================================================
    // shared tasks
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bounded wait for standby (sb=1) or battery state to reach v
    task wait_st(input logic sb, input logic v);
        for (k = 0; k < 10 && (sb ? o_standby : o_on_battery) !== v; k++) @(posedge i_clk_sys);
        chk({7'h0, sb ? o_standby : o_on_battery}, {7'h0, v});
        if (k == 10) report_and_stop;
    endtask
    task sup(input logic b, input logic s);
        @(posedge i_clk_sys);
        lt_b  <= b;
        lt_sw <= s;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        i_bpfl_host.rd(8'h02, d); chk(d, 8'he0);
        i_bpfl_host.rd(8'h03, d); chk(d, 8'h80);
        i_bpfl_host.rd(8'h0f, d); chk(d, 8'h00);
        i_bpfl_host.wr(8'h03, 8'h00);
        i_bpfl_host.rd(8'h03, d); chk(d, 8'h80);
        @(posedge i_clk_sys) osc <= 1'b1;
        i_bpfl_host.wr(8'h03, 8'h80);
        i_bpfl_host.rd(8'h03, d); chk(d, 8'h80);
        i_bpfl_host.wr(8'h03, 8'h00);
        i_bpfl_host.rd(8'h03, d); chk(d, 8'h00);
        // clock output shares the interrupt pin and floats it once disabled
        i_bpfl_host.wr(8'h01, 8'h01);
        @(posedge i_clk_sys) ck_n <= 1'b0;
        @(posedge i_clk_sys) #1 chk({7'h0, o_int_n_oe}, 8'h01);
        i_bpfl_host.rd(8'h01, d); chk(d, 8'h01);
        i_bpfl_host.wr(8'h01, 8'h00);
        #1 chk({7'h0, o_int_n_oe}, 8'h00);
        @(posedge i_clk_sys) ck_n <= 1'b1;
        // low detection off for the first three codes, on for the rest
        @(posedge i_clk_sys) low <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            i_bpfl_host.wr(8'h02, {codes[i], 5'h01});
            i_bpfl_host.rd(8'h02, d); chk(d, {codes[i], 2'b00, i > 2, 2'b01});
            chk({7'h0, o_int_n_oe}, {7'h0, i > 2});
        end
        i_bpfl_host.wr(8'h02, 8'h60);
        i_bpfl_host.rd(8'h02, d); chk(d, 8'h64);
        chk({7'h0, o_int_n_oe}, 8'h00);
        @(posedge i_clk_sys) low <= 1'b0;
        i_bpfl_host.rd(8'h02, d); chk(d, 8'h60);
        // switchover disabled: losing main means standby, no flag
        sup(1'b1, 1'b1);
        wait_st(1'b1, 1'b1);
        chk({7'h0, o_if_oe}, 8'h00);
        sup(1'b0, 1'b0);
        wait_st(1'b1, 1'b0);
        i_bpfl_host.rd(8'h02, d); chk(d, 8'h60);
        // standard mode with switchover interrupt
        i_bpfl_host.wr(8'h02, 8'h02);
        sup(1'b1, 1'b0);
        repeat (4) @(posedge i_clk_sys);
        chk({7'h0, o_on_battery}, 8'h00);
        sup(1'b1, 1'b1);
        wait_st(1'b0, 1'b1);
        i_bpfl_host.wr(8'h02, 8'he0);
        sup(1'b0, 1'b0);
        wait_st(1'b0, 1'b0);
        i_bpfl_host.rd(8'h02, d); chk(d, 8'h0a);
        chk({7'h0, o_int_n_oe}, 8'h01);
        i_bpfl_host.wr(8'h02, 8'h02);
        i_bpfl_host.rd(8'h02, d); chk(d, 8'h02);
        chk({7'h0, o_int_n_oe}, 8'h00);
        // direct mode, interrupt disabled
        i_bpfl_host.wr(8'h02, 8'h20);
        sup(1'b1, 1'b0);
        wait_st(1'b0, 1'b1);
        sup(1'b0, 1'b0);
        wait_st(1'b0, 1'b0);
        i_bpfl_host.rd(8'h02, d); chk(d, 8'h28);
        chk({7'h0, o_int_n_oe}, 8'h00);
        // power-on from the battery alone starts in standby
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        lt_b  <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        wait_st(1'b1, 1'b1);
        sup(1'b0, 1'b0);
        wait_st(1'b1, 1'b0);
        report_and_stop;
    end
endmodule // tb_bpfl_top
